/* File: common/cfr_link_if.sv */
`timescale 1ns/10ps
interface cfr_link_if;
    // Index 0 top set (shared by both top quadrants), 1 bottom set
    logic [1:0][3:0]                 vertical_image_phases;
    logic [1:0]                      line_transfer_gate;
    logic                            vert_high_level;
    // Index: output 0 top-left, 1 top-right, 2 bottom-left, 3 bottom-right
    logic [3:0][2:0][5:0]            horizontal_shift_phases;
    logic [3:0][5:0]                 summing_gate;
    logic [3:0][5:0]                 node_reset_gate;
    logic                            substrate_bias_pulse;
    logic [4:0]                      supply_en;

    modport ctrl (
        output vertical_image_phases,
        output line_transfer_gate,
        output vert_high_level,
        output horizontal_shift_phases,
        output summing_gate,
        output node_reset_gate,
        output substrate_bias_pulse,
        output supply_en
    );

    modport sensor (
        input vertical_image_phases,
        input line_transfer_gate,
        input vert_high_level,
        input horizontal_shift_phases,
        input summing_gate,
        input node_reset_gate,
        input substrate_bias_pulse,
        input supply_en
    );
endinterface

/* File: common/cfr_map.svh */
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// ==========================================================
// Rates and derived cycle counts
`define CFR_PIX_HZ        25000000
`define CFR_VERT_HZ       50000
`define CFR_LINE_CYC      3735
`define CFR_VERT_CYC      (`CFR_PIX_HZ / `CFR_VERT_HZ)
`define CFR_VERT_HIGH     ((`CFR_VERT_CYC * 5) / 8)
`define CFR_VERT_QTR      (`CFR_VERT_CYC / 4)
`define CFR_PVT_CYC       `CFR_VERT_CYC
`define CFR_FLUSH_MIN_US  10
`define CFR_FLUSH_MIN_CYC ((`CFR_FLUSH_MIN_US * (`CFR_PIX_HZ / 1000000)))
`define CFR_POWER_STEP    250

// ==========================================================
// Array geometry
`define CFR_TOTAL_LINES   8082
`define CFR_ACTIVE_LINES  8000
`define CFR_REG_CELLS     6094
`define CFR_DUMMY_CELLS   46
`define CFR_HALF_CELLS    (`CFR_REG_CELLS / 2)

// ==========================================================
// Sixth-slot waveform words, bit 0 is the first sixth
`define CFR_H1_RUN        6'h07
`define CFR_H2_RUN        6'h1c
`define CFR_H3_RUN        6'h31
`define CFR_RST_RUN       6'h01
`define CFR_WORD_HIGH     6'h3f
`define CFR_WORD_LOW      6'h00

// ==========================================================
// Image phase patterns
`define CFR_A_INTEG       4'h3
`define CFR_A_PVT         4'h6
`define CFR_A_FLUSH       4'h0

`endif

/* File: common/cfr_pkg.sv */
package cfr_pkg;

    typedef enum logic [6:0] {
        CFR_ST_POWER = 7'h01,
        CFR_ST_IDLE  = 7'h02,
        CFR_ST_FLUSH = 7'h04,
        CFR_ST_INTEG = 7'h08,
        CFR_ST_PVT   = 7'h10,
        CFR_ST_VERT  = 7'h20,
        CFR_ST_HORZ  = 7'h40
    } cfr_state_t;

    typedef enum logic [1:0] {
        CFR_MODE_TOP    = 2'h0,
        CFR_MODE_BOTTOM = 2'h1,
        CFR_MODE_SPLIT  = 2'h2
    } cfr_mode_t;

    // Six sub-slot levels of one pixel period
    typedef logic [5:0] cfr_word_t;

    typedef struct packed {
        cfr_state_t  st;
        logic [2:0]  pwr;
        logic [15:0] pcnt;
        logic [11:0] cyc;
        logic [12:0] line;
        logic [11:0] pix;
        logic        trig;
    } cfr_ctrl_t;

    typedef struct packed {
        logic [12:0]      line;
        logic [3:0][11:0] cells;
        logic [3:0]       strobe;
        logic             flushed;
        logic             order_err;
        logic [1:0]       xfer_prev;
        logic             flush_prev;
    } cfr_dev_t;

endpackage

/* File: src/cfr_ctrl.sv */
`timescale 1ns/10ps
`include "cfr_map.svh"
// Contract
// - Shift one line per step to chosen register
// - Register halves clocked independently per output
// - Third horizontal phase held during line shift
// - Summing gate at each end bins pixels
// - Reset gate pulsed one sixth per pixel
// - Line counter spans all 8082 lines, 4041 steps in split mode
// - Pixel counter shifts whole register half
// - Two image gates integrate, two block
// - Vertical phases five eighths high, higher level
// - Transfer gate follows phase one, low skips
// - Horizontal phases 25 MHz, three sixths duty
// - Vertical transport clocked at 50 kHz
// - Line period is 3735 pixel cycles
// - Charge flush first line after trigger rise
// - Integrate while exposure trigger high
// - Return idle after full readout
// - Prepare transport before bottom outputs used
// - Flush with image phases low, substrate pulse
// - Supplies enabled in fixed order
// - Quadrant pairs share one vertical set
module cfr_ctrl #(
    parameter int unsigned POWER_STEP_CYC = `CFR_POWER_STEP
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              exposure_trig,
    input  wire cfr_pkg::cfr_mode_t readout_mode,
    input  wire logic [1:0]        half_en,
    input  wire logic              bin_en,
    input  wire logic              skip_line,
    output logic                   ready,
    output logic                   supplies_up,
    output logic [12:0]            line_index,
    cfr_link_if.ctrl               link
);

    // ==========================================================
    // Helpers
    function automatic logic vphase(input logic [11:0] cyc,
                                    input int unsigned k);
        int unsigned p;
        p = (int'(cyc) + `CFR_VERT_CYC - k * `CFR_VERT_QTR)
            % `CFR_VERT_CYC;
        return p < `CFR_VERT_HIGH;
    endfunction

    function automatic logic [12:0] line_limit(input cfr_pkg::cfr_mode_t m);
        // Split readout empties both registers at once
        if (m == cfr_pkg::CFR_MODE_SPLIT)
            return 13'(`CFR_TOTAL_LINES / 2);
        else
            return 13'(`CFR_TOTAL_LINES);
    endfunction

    function automatic logic uses_bottom(input cfr_pkg::cfr_mode_t m);
        return m != cfr_pkg::CFR_MODE_TOP;
    endfunction

    // ==========================================================
    // State
    cfr_pkg::cfr_ctrl_t s_q;
    cfr_pkg::cfr_ctrl_t s_d;
    logic               last_cyc;

    assign last_cyc = s_q.cyc == 12'(`CFR_LINE_CYC - 1);

    always_comb
    begin
        s_d      = s_q;
        s_d.trig = exposure_trig;
        case (s_q.st)
            cfr_pkg::CFR_ST_POWER:
            begin
                // Stage n waits a step, then enables supply n
                if (s_q.pcnt == 16'(POWER_STEP_CYC - 1))
                begin
                    s_d.pcnt = 16'h0000;
                    s_d.pwr  = s_q.pwr + 3'h1;
                    if (s_q.pwr == 3'h4)
                        s_d.st = cfr_pkg::CFR_ST_IDLE;
                end
                else
                    s_d.pcnt = s_q.pcnt + 16'h0001;
            end
            cfr_pkg::CFR_ST_IDLE:
            begin
                s_d.cyc  = 12'h000;
                s_d.line = 13'h0000;
                if (exposure_trig && !s_q.trig)
                    s_d.st = cfr_pkg::CFR_ST_FLUSH;
            end
            cfr_pkg::CFR_ST_FLUSH:
            begin
                // One full line, well above the 10 us minimum
                s_d.cyc = s_q.cyc + 12'h001;
                if (last_cyc)
                begin
                    s_d.cyc = 12'h000;
                    s_d.st  = cfr_pkg::CFR_ST_INTEG;
                end
            end
            cfr_pkg::CFR_ST_INTEG:
            begin
                if (!exposure_trig)
                    s_d.st = uses_bottom(readout_mode) ?
                             cfr_pkg::CFR_ST_PVT :
                             cfr_pkg::CFR_ST_VERT;
            end
            cfr_pkg::CFR_ST_PVT:
            begin
                s_d.cyc = s_q.cyc + 12'h001;
                if (s_q.cyc == 12'(`CFR_PVT_CYC - 1))
                begin
                    s_d.cyc = 12'h000;
                    s_d.st  = cfr_pkg::CFR_ST_VERT;
                end
            end
            cfr_pkg::CFR_ST_VERT:
            begin
                s_d.cyc = s_q.cyc + 12'h001;
                s_d.pix = 12'h000;
                if (s_q.cyc == 12'(`CFR_VERT_CYC - 1))
                    s_d.st = cfr_pkg::CFR_ST_HORZ;
            end
            cfr_pkg::CFR_ST_HORZ:
            begin
                s_d.cyc = s_q.cyc + 12'h001;
                if (s_q.pix != 12'(`CFR_HALF_CELLS))
                    s_d.pix = s_q.pix + 12'h001;
                if (last_cyc)
                begin
                    s_d.cyc  = 12'h000;
                    s_d.line = s_q.line + 13'h0001;
                    if (s_q.line == line_limit(readout_mode) - 13'h0001)
                        s_d.st = cfr_pkg::CFR_ST_IDLE;
                    else
                        s_d.st = cfr_pkg::CFR_ST_VERT;
                end
            end
            default:
                s_d.st = cfr_pkg::CFR_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q.st   <= cfr_pkg::CFR_ST_POWER;
            s_q.pwr  <= 3'h0;
            s_q.pcnt <= 16'h0000;
            s_q.cyc  <= 12'h000;
            s_q.line <= 13'h0000;
            s_q.pix  <= 12'h000;
            s_q.trig <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    // ==========================================================
    // Phase decode
    logic [3:0] out_en;
    logic       shifting;
    logic [3:0] a_fwd;
    logic       vert;

    assign vert     = s_q.st == cfr_pkg::CFR_ST_VERT;
    assign shifting = s_q.st == cfr_pkg::CFR_ST_HORZ &&
                      s_q.pix != 12'(`CFR_HALF_CELLS);

    always_comb
    begin
        out_en[0] = readout_mode != cfr_pkg::CFR_MODE_BOTTOM && half_en[0];
        out_en[1] = readout_mode != cfr_pkg::CFR_MODE_BOTTOM && half_en[1];
        out_en[2] = uses_bottom(readout_mode) && half_en[0];
        out_en[3] = uses_bottom(readout_mode) && half_en[1];
        for (int k = 0; k < 4; k++)
            a_fwd[k] = vphase(s_q.cyc, k);
    end

    always_comb
    begin
        for (int side = 0; side < 2; side++)
        begin
            // Charge moves up in top mode, down in bottom mode; split moves the top set up, the bottom set down
            case (s_q.st)
                cfr_pkg::CFR_ST_FLUSH:
                    link.vertical_image_phases[side] = `CFR_A_FLUSH;
                cfr_pkg::CFR_ST_PVT:
                    link.vertical_image_phases[side] = `CFR_A_PVT;
                cfr_pkg::CFR_ST_VERT:
                    if (readout_mode == cfr_pkg::CFR_MODE_BOTTOM ||
                        (readout_mode == cfr_pkg::CFR_MODE_SPLIT &&
                         side == 1))
                        // Phase one kept, so the gate opens once a step
                        link.vertical_image_phases[side] =
                            {a_fwd[1], a_fwd[2], a_fwd[3], a_fwd[0]};
                    else
                        link.vertical_image_phases[side] = a_fwd;
                default:
                    link.vertical_image_phases[side] = `CFR_A_INTEG;
            endcase
            // Skipped line keeps the register closed
            link.line_transfer_gate[side] = vert && !skip_line &&
                link.vertical_image_phases[side][0];
        end
        for (int o = 0; o < 4; o++)
        begin
            if (!out_en[o])
            begin
                // Unused halves parked low
                link.horizontal_shift_phases[o] = '0;
                link.summing_gate[o]            = `CFR_WORD_LOW;
                link.node_reset_gate[o]         = `CFR_WORD_LOW;
            end
            else if (shifting)
            begin
                link.horizontal_shift_phases[o][0] = `CFR_H1_RUN;
                link.horizontal_shift_phases[o][1] = `CFR_H2_RUN;
                link.horizontal_shift_phases[o][2] = `CFR_H3_RUN;
                // Binning: gate held high on even cells collects two
                if (bin_en && !s_q.pix[0])
                begin
                    link.summing_gate[o]    = `CFR_WORD_HIGH;
                    link.node_reset_gate[o] = `CFR_WORD_LOW;
                end
                else
                begin
                    link.summing_gate[o]    = `CFR_H3_RUN;
                    link.node_reset_gate[o] = `CFR_RST_RUN;
                end
            end
            else
            begin
                link.horizontal_shift_phases[o][0] = `CFR_WORD_LOW;
                link.horizontal_shift_phases[o][1] = `CFR_WORD_LOW;
                link.horizontal_shift_phases[o][2] = `CFR_WORD_HIGH;
                link.summing_gate[o]               = `CFR_WORD_HIGH;
                link.node_reset_gate[o]            = `CFR_WORD_LOW;
            end
        end
        for (int i = 0; i < 5; i++)
            link.supply_en[i] = s_q.pwr > 3'(i);
    end

    assign link.vert_high_level      = vert;
    assign link.substrate_bias_pulse = s_q.st == cfr_pkg::CFR_ST_FLUSH;
    assign ready       = s_q.st == cfr_pkg::CFR_ST_IDLE;
    assign supplies_up = s_q.pwr == 3'h5;
    assign line_index  = s_q.line;

endmodule

/* File: src/cfr_sensor.sv */
`timescale 1ns/10ps
`include "cfr_map.svh"
module cfr_sensor (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    cfr_link_if.sensor             link,
    output logic [12:0]            lines_moved,
    output logic [3:0][11:0]       cells_out,
    output logic [3:0]             pixel_strobe,
    output logic                   flush_done,
    output logic                   supply_order_err
);

    cfr_pkg::cfr_dev_t s_q;
    cfr_pkg::cfr_dev_t s_d;

    // ==========================================================
    // Line, cell and conversion tracking
    always_comb
    begin
        logic flush_now;
        logic shift_now;
        flush_now     = 1'b0;
        shift_now     = 1'b0;
        s_d           = s_q;
        s_d.xfer_prev = link.line_transfer_gate;
        // Only enable bits set ahead of their predecessor are faults
        for (int i = 1; i < 5; i++)
            if (link.supply_en[i] && !link.supply_en[i-1])
                s_d.order_err = 1'b1;
        flush_now      = link.substrate_bias_pulse &&
                         link.vertical_image_phases[0] == `CFR_A_FLUSH &&
                         link.vertical_image_phases[1] == `CFR_A_FLUSH;
        s_d.flush_prev = flush_now;
        s_d.flushed    = s_q.flush_prev && !flush_now;
        if (flush_now)
            s_d.line = 13'h0000;
        // Either set moving a line counts once, both halves share it
        shift_now = |(link.line_transfer_gate & ~s_q.xfer_prev);
        if (shift_now && s_q.line != 13'(`CFR_TOTAL_LINES))
            s_d.line = s_q.line + 13'h0001;
        for (int o = 0; o < 4; o++)
        begin
            if (shift_now)
                s_d.cells[o] = 12'h000;
            else if (link.horizontal_shift_phases[o][2] == `CFR_H3_RUN &&
                     s_q.cells[o] != 12'(`CFR_HALF_CELLS))
                s_d.cells[o] = s_q.cells[o] + 12'h001;
            // Each half has its own clocks, so outputs run apart
            s_d.strobe[o] = link.node_reset_gate[o] != `CFR_WORD_LOW &&
                            link.summing_gate[o] != `CFR_WORD_HIGH;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q.line       <= 13'h0000;
            s_q.cells      <= '0;
            s_q.strobe     <= 4'h0;
            s_q.flushed    <= 1'b0;
            s_q.order_err  <= 1'b0;
            s_q.xfer_prev  <= 2'h0;
            s_q.flush_prev <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign lines_moved      = s_q.line;
    assign cells_out        = s_q.cells;
    assign pixel_strobe     = s_q.strobe;
    assign flush_done       = s_q.flushed;
    assign supply_order_err = s_q.order_err;

endmodule

/* File: verification/cfr_link_asserts.sv */
`timescale 1ns/10ps
// ==========================================================
// Link checker, watches both ends from outside
module cfr_link_asserts (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic [1:0][3:0]      vertical_image_phases,
    input  wire logic [1:0]           line_transfer_gate,
    input  wire logic                 vert_high_level,
    input  wire logic [3:0][2:0][5:0] horizontal_shift_phases,
    input  wire logic [3:0][5:0]      summing_gate,
    input  wire logic [3:0][5:0]      node_reset_gate,
    input  wire logic                 substrate_bias_pulse,
    input  wire logic [4:0]           supply_en
);
    logic [11:0] flush_q;
    logic [11:0] vcnt_q;
    logic [11:0] gap_q;
    logic        armed_q;
    logic        hold_ok;
    logic        rst_ok;
    logic        run_ok;
    logic        sum_ok;

    // Gap check armed only after a first step, so the frame start is skipped
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flush_q <= 12'h000;
            vcnt_q  <= 12'h000;
            gap_q   <= 12'h000;
            armed_q <= 1'b0;
        end
        else
        begin
            flush_q <= substrate_bias_pulse ? flush_q + 12'h001 : 12'h000;
            vcnt_q  <= vert_high_level ? vcnt_q + 12'h001 : 12'h000;
            gap_q   <= (vert_high_level || !armed_q) ? 12'h000
                                                     : gap_q + 12'h001;
            armed_q <= !substrate_bias_pulse && (armed_q || vert_high_level);
        end
    end

    always_comb
    begin
        hold_ok = 1'b1;
        rst_ok  = 1'b1;
        run_ok  = 1'b1;
        sum_ok  = 1'b1;
        for (int o = 0; o < 4; o++)
        begin
            hold_ok &= (horizontal_shift_phases[o][2] == 6'h3f)
                    || (horizontal_shift_phases[o] == 18'h00000);
            rst_ok  &= node_reset_gate[o] == 6'h00
                    || node_reset_gate[o] == 6'h01;
            run_ok &= horizontal_shift_phases[o][0] != 6'h07
                   || (horizontal_shift_phases[o][1] == 6'h1c
                   && horizontal_shift_phases[o][2] == 6'h31);
            sum_ok &= node_reset_gate[o] == 6'h00 || summing_gate[o] == 6'h31;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_flush_phases_low: assert property (
        substrate_bias_pulse |-> vertical_image_phases == 8'h00)
        else $error("image phases not low in flush");
    a_flush_line_len: assert property (
        $fell(substrate_bias_pulse) |-> flush_q == 12'he97)
        else $error("flush not one line long");
    a_third_holds: assert property (
        vert_high_level |-> hold_ok)
        else $error("third phase moved during line shift");
    a_xfer_follows_ph1: assert property (
        line_transfer_gate[0] |-> vertical_image_phases[0][0])
        else $error("transfer gate high without phase one");
    a_two_gates_integ: assert property (
        !vert_high_level && !substrate_bias_pulse
        |-> $countones(vertical_image_phases[0]) == 2
         && $countones(vertical_image_phases[1]) == 2)
        else $error("not two gates high outside transport");
    a_rst_one_sixth: assert property (
        rst_ok)
        else $error("reset gate word not one sixth");
    a_hphase_run: assert property (
        run_ok)
        else $error("horizontal phases out of step");
    a_rst_with_sum: assert property (
        sum_ok)
        else $error("reset gate not aligned to summing gate");
    a_supply_order: assert property (
        (supply_en & (supply_en + 5'h01)) == 5'h00)
        else $error("supply enabled out of order");
    a_vert_step_len: assert property (
        $fell(vert_high_level) |-> vcnt_q == 12'h1f4)
        else $error("vertical step not 500 cycles");
    a_line_period: assert property (
        $rose(vert_high_level) && armed_q |-> gap_q == 12'hca3)
        else $error("line period wrong");
endmodule

/* File: verification/test_ccd_frame_readout_timing.sv */
`timescale 1ns/10ps
`define CHK(nm, ev, gv) \
    begin \
        checks++; \
        if ((gv) !== (ev)) \
        begin \
            err_total++; \
            $display("wrong value %s expected %0h seen %0h", nm, ev, gv); \
        end \
    end
// ==========================================================
// Both ends joined, bench drives the controller's user side
module test_ccd_frame_readout_timing;
    logic               sys_clk;
    logic               sys_rst;
    logic               exposure_trig;
    cfr_pkg::cfr_mode_t readout_mode;
    logic [1:0]         half_en;
    logic               bin_en;
    logic               skip_line;
    logic               ready;
    logic               supplies_up;
    logic [12:0]        line_index;
    logic [12:0]        lines_moved;
    logic [3:0][11:0]   cells_out;
    logic [3:0]         pixel_strobe;
    logic               flush_done;
    logic               supply_order_err;
    int                 err_total;
    int                 checks;
    int                 m_vert;
    int                 m_hi;
    int                 m_wait;
    int                 m_pvt;
    int                 m_xg[2];
    int                 m_str[4];
    logic [3:0][11:0]   m_cells;
    logic [12:0]        m_moved;
    logic [12:0]        m_index;

    cfr_link_if link_bus ();
    cfr_ctrl #(.POWER_STEP_CYC(4)) cfr_ctrl_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .exposure_trig(exposure_trig), .readout_mode(readout_mode),
        .half_en(half_en), .bin_en(bin_en), .skip_line(skip_line),
        .ready(ready), .supplies_up(supplies_up),
        .line_index(line_index), .link(link_bus));
    cfr_sensor cfr_sensor_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_bus),
        .lines_moved(lines_moved), .cells_out(cells_out),
        .pixel_strobe(pixel_strobe), .flush_done(flush_done),
        .supply_order_err(supply_order_err));
    cfr_link_asserts cfr_link_asserts_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .vertical_image_phases(link_bus.vertical_image_phases),
        .line_transfer_gate(link_bus.line_transfer_gate),
        .vert_high_level(link_bus.vert_high_level),
        .horizontal_shift_phases(link_bus.horizontal_shift_phases),
        .summing_gate(link_bus.summing_gate),
        .node_reset_gate(link_bus.node_reset_gate),
        .substrate_bias_pulse(link_bus.substrate_bias_pulse),
        .supply_en(link_bus.supply_en));

    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // Shared tasks
    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic bad_wait(string nm);
        err_total++;
        $display("wrong value %s exp event got timeout", nm);
        final_report();
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        exposure_trig = 1'b0;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
    endtask

    task automatic start_frame(cfr_pkg::cfr_mode_t md, logic [1:0] he,
                               logic bn, logic sk);
        int n;
        int bad;
        int fd;
        readout_mode = md;
        half_en = he;
        bin_en = bn;
        skip_line = sk;
        repeat (2) @(negedge sys_clk);
        exposure_trig = 1'b1;
        n = 0;
        bad = 0;
        fd = 0;
        while (link_bus.substrate_bias_pulse !== 1'b1)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 5)
                bad_wait("flush start");
        end
        n = 0;
        while (link_bus.substrate_bias_pulse === 1'b1 && n < 4000)
        begin
            bad += (link_bus.vertical_image_phases !== 8'h00);
            @(negedge sys_clk);
            n++;
        end
        `CHK("flush length", 3735, n)
        `CHK("flush phases", 0, bad)
        // Trigger still high here: phases must sit in integration
        repeat (20)
        begin
            @(negedge sys_clk);
            fd += (flush_done === 1'b1);
            bad += (link_bus.vertical_image_phases !== 8'h33);
        end
        `CHK("flush done", 1, fd)
        `CHK("integration hold", 0, bad)
        exposure_trig = 1'b0;
    endtask

    // One full line from the first vertical cycle
    task automatic measure_line();
        logic [1:0] xg_prev;
        m_wait = 0;
        m_pvt = 0;
        while (link_bus.vert_high_level !== 1'b1)
        begin
            m_pvt += (link_bus.vertical_image_phases[1] === 4'h6);
            @(negedge sys_clk);
            m_wait++;
            if (m_wait > 1000)
                bad_wait("vertical step");
        end
        m_vert = 0;
        m_hi = 0;
        m_xg = '{0, 0};
        m_str = '{0, 0, 0, 0};
        xg_prev = 2'b00;
        for (int i = 0; i < 3735; i++)
        begin
            m_vert += link_bus.vert_high_level;
            m_hi += link_bus.vert_high_level
                  & link_bus.vertical_image_phases[0][0];
            for (int s = 0; s < 2; s++)
                m_xg[s] += link_bus.line_transfer_gate[s] & !xg_prev[s];
            xg_prev = link_bus.line_transfer_gate;
            for (int o = 0; o < 4; o++)
                m_str[o] += pixel_strobe[o];
            m_cells = cells_out;
            m_moved = lines_moved;
            m_index = line_index;
            @(negedge sys_clk);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic s_power_up();
        int n;
        n = 0;
        while (ready !== 1'b1)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 100)
                bad_wait("ready");
        end
        `CHK("supply_en", 5'h1f, link_bus.supply_en)
        `CHK("supplies_up", 1'b1, supplies_up)
        `CHK("supply_order_err", 1'b0, supply_order_err)
        `CHK("power delay", 1'b1, n >= 19 && n <= 22)
    endtask

    task automatic s_top_frame();
        logic [12:0] first_index;
        start_frame(cfr_pkg::CFR_MODE_TOP, 2'b11, 1'b0, 1'b0);
        measure_line();
        first_index = m_index;
        `CHK("prepare cycles top", 0, m_pvt)
        `CHK("vert cycles", 500, m_vert)
        `CHK("phase one high", 312, m_hi)
        `CHK("top xfer rises", 1, m_xg[0])
        `CHK("cells tl", 12'hbe7, m_cells[0])
        `CHK("cells tr", 12'hbe7, m_cells[1])
        `CHK("strobes tl", 3047, m_str[0])
        `CHK("strobes bl", 0, m_str[2])
        `CHK("moved one", 13'h0001, m_moved)
        `CHK("ready in frame", 1'b0, ready)
        measure_line();
        `CHK("line gap", 0, m_wait)
        `CHK("moved two", 13'h0002, m_moved)
        `CHK("index step", first_index + 13'h0001, m_index)
    endtask

    task automatic s_split_frame();
        start_frame(cfr_pkg::CFR_MODE_SPLIT, 2'b01, 1'b1, 1'b0);
        measure_line();
        `CHK("prepare cycles", 500, m_pvt)
        `CHK("top xfer", 1, m_xg[0])
        `CHK("bottom xfer", 1, m_xg[1])
        `CHK("binned tl", 1523, m_str[0])
        `CHK("binned bl", 1523, m_str[2])
        `CHK("idle tr", 0, m_str[1])
        `CHK("idle tr cells", 12'h000, m_cells[1])
        `CHK("cells bl", 12'hbe7, m_cells[2])
    endtask

    task automatic s_skip_bottom();
        start_frame(cfr_pkg::CFR_MODE_BOTTOM, 2'b10, 1'b0, 1'b1);
        measure_line();
        `CHK("prepare bottom", 500, m_pvt)
        `CHK("skip xfer", 0, m_xg[1])
        `CHK("skip moved", 13'h0000, m_moved)
        `CHK("strobes br", 3047, m_str[3])
        `CHK("strobes bl off", 0, m_str[2])
    endtask

    initial
    begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        exposure_trig = 1'b0;
        readout_mode = cfr_pkg::CFR_MODE_TOP;
        half_en = 2'b00;
        bin_en = 1'b0;
        skip_line = 1'b0;
        err_total = 0;
        checks = 0;
        do_reset();
        s_power_up();
        s_top_frame();
        do_reset();
        s_power_up();
        s_split_frame();
        do_reset();
        s_power_up();
        s_skip_bottom();
        final_report();
    end
endmodule
